// *** bench/cpu_bus_model.sv ***
// Bus master model standing in for the processor core
`timescale 1ns/10ps
module cpu_bus_model (
  input wire logic clk_sys,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic rd_done,
  output logic [7:0] rd_byte
);
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    rd_done = 1'b0;
    rd_byte = 8'h00;
  end
  // One access at a time, never split by other code
  task automatic xfer(input logic wr, input logic [7:0] ofs,
    input logic [7:0] dat);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, ofs};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, dat}; // Data rides in the low byte lane
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hwdata <= {24'hFFFFFF, ~dat};
    rd_byte <= hrdata[7:0];
    rd_done <= !wr;
    @(posedge clk_sys);
    rd_done <= 1'b0;
  endtask
endmodule

// *** bench/wide_timer_core_byte_access_test.sv ***
// Self-checking bench for the byte-accessed 16-bit timer core
`timescale 1ns/10ps
module wide_timer_core_byte_access_test
  import wide_timer_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] pins = 3'b000;
  logic hsel, hwrite, hreadyout, hresp, rd_done, wa, wb;
  logic wave_out_a, wave_out_b, bottom_flag, max_flag, top_flag, irq_req;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rd_byte;
  logic [15:0] e;
  logic [15:0] exp_q[$];
  logic [2:0] sel_list [6] = '{TOPSEL_MAX, TOPSEL_8, TOPSEL_9, TOPSEL_10,
    TOPSEL_CAPT, TOPSEL_CMPA};
  logic [15:0] top_list [6] = '{MAX_VAL, TOP_8BIT, TOP_9BIT, TOP_10BIT,
    16'h0456, 16'h1234};
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int seed = 60347;

  cpu_bus_model i_cpu_bus_model (.clk_sys(clk_sys),
    .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .rd_done(rd_done), .rd_byte(rd_byte));
  wide_timer_core i_wide_timer_core (.clk_sys(clk_sys), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_count_pin(pins[0]), .capture_pin(pins[1]),
    .comparator_out(pins[2]), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .bottom_flag(bottom_flag),
    .max_flag(max_flag), .top_flag(top_flag), .irq_req(irq_req));

  // Free-running 50 MHz clock
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cut a hung run short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      summarize();
    end
  end

  // Compare each read byte with the oldest note; empty queue never matches
  always @(posedge clk_sys) begin
    if (rd_done === 1'b1) begin
      e = (exp_q.size() != 0) ? exp_q.pop_front() : 16'h0001;
      num_checks++;
      if ((rd_byte & e[15:8]) !== e[7:0]) begin
        err_count++;
        $display("mismatch at %0t: read %h want %h", $time, rd_byte, e);
      end
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  // Let registered outputs follow the last write
  task automatic settle();
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic wr8(input logic [7:0] ofs, input logic [7:0] d);
    i_cpu_bus_model.xfer(1'b1, ofs, d);
  endtask
  task automatic rd8(input logic [7:0] ofs, input logic [7:0] d,
    input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, d & m});
    i_cpu_bus_model.xfer(1'b0, ofs, 8'h00);
  endtask
  // High byte first on writes, low byte first on reads
  task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
    wr8(lo + 8'h04, d[15:8]);
    wr8(lo, d[7:0]);
  endtask
  task automatic rd16(input logic [7:0] lo, input logic [15:0] d);
    rd8(lo, d[7:0]);
    rd8(lo + 8'h04, d[15:8]);
  endtask
  // Pin pulses: 0 count pin, 1 capture pin, 2 comparator
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      pins[p] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      pins[p] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    settle();
    chk(bottom_flag, 1'b1, "bottom at reset");
    chk(hresp, 1'b0, "response not okay");
    rd8(OFS_POWER, POWER_RST);
    rd16(OFS_COUNT_LO, 16'h0000);
    rd8(8'h3C, 8'h00);
    $display("test reset done");
    wr8(OFS_POWER, 8'h00);
    v = $random(seed);
    wr8(OFS_COUNT_HI, v[15:8]);
    wr8(OFS_CMPA_LO, v[7:0]);
    wr8(OFS_CMPB_LO, v[23:16]);
    rd16(OFS_COUNT_LO, 16'h0000);
    wr16(OFS_COUNT_LO, {~v[15:8], v[31:24]});
    rd8(OFS_COUNT_LO, v[31:24]);
    rd8(OFS_CMPA_HI, v[15:8]);
    rd8(OFS_CMPB_LO, v[23:16]);
    rd8(OFS_COUNT_HI, ~v[15:8]);
    rd8(OFS_CMPB_HI, v[15:8]);
    wr16(OFS_CAPT_LO, v[31:16]);
    rd16(OFS_CAPT_LO, v[31:16]);
    $display("test holding register done");
    wr16(OFS_COUNT_LO, 16'h0010);
    wr8(OFS_POWER, 8'h01);
    wr8(OFS_CTRL_B, {5'h0, CS_DIV1});
    repeat (10) @(posedge clk_sys);
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    wr8(OFS_POWER, 8'h00);
    rd16(OFS_COUNT_LO, 16'h0010);
    wr8(OFS_CTRL_B, {5'h0, CS_DIV1});
    wr16(OFS_COUNT_LO, 16'h1200);
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    rd8(OFS_COUNT_LO, 8'h00, 8'hE0);
    rd8(OFS_COUNT_HI, 8'h12);
    $display("test gate and priority done");
    wr16(OFS_CMPA_LO, 16'h0006);
    wr16(OFS_CMPB_LO, 16'h0008);
    wr16(OFS_COUNT_LO, 16'h0000);
    wr8(OFS_FLAG, 8'h0F);
    settle();
    wa = wave_out_a;
    wb = wave_out_b;
    wr8(OFS_CTRL_B, {5'h0, CS_EXT_RISE});
    pulse(0, 10);
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    rd16(OFS_COUNT_LO, 16'h000A);
    rd8(OFS_FLAG, 8'h06);
    settle();
    chk(wave_out_a, !wa, "wave a");
    chk(wave_out_b, !wb, "wave b");
    chk(irq_req, 1'b0, "irq while masked");
    wr8(OFS_MASK, 8'h02);
    settle();
    chk(irq_req, 1'b1, "irq a");
    wr8(OFS_FLAG, 8'h02);
    rd8(OFS_FLAG, 8'h04);
    settle();
    chk(irq_req, 1'b0, "irq after clear");
    wr8(OFS_MASK, 8'h04);
    settle();
    chk(irq_req, 1'b1, "irq b");
    wr8(OFS_MASK, 8'h00);
    wr16(OFS_COUNT_LO, 16'h0000);
    wr8(OFS_CTRL_B, {5'h0, CS_EXT_FALL});
    pulse(0, 3);
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    rd16(OFS_COUNT_LO, 16'h0003);
    $display("test compare and flags done");
    for (int s = 0; s < 2; s++) begin
      v = $random(seed);
      wr8(OFS_CTRL_B, (s == 0) ? 8'h40 : 8'h60);
      wr16(OFS_COUNT_LO, v[15:0]);
      wr8(OFS_FLAG, 8'h0F);
      pulse(s + 1, 1);
      rd16(OFS_CAPT_LO, v[15:0]);
      rd8(OFS_FLAG, 8'h08, 8'h08);
    end
    $display("test capture done");
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    wr16(OFS_CMPA_LO, 16'h1234);
    wr16(OFS_CAPT_LO, 16'h0456);
    settle();
    wa = wave_out_a;
    for (int i = 0; i < 6; i++) begin
      wr8(OFS_CTRL_A, {5'h0, sel_list[i]});
      wr16(OFS_COUNT_LO, top_list[i]);
      settle();
      chk(top_flag, 1'b1, "top flag");
      chk(max_flag, top_list[i] == MAX_VAL, "max flag");
      chk(wave_out_a, (i == 5) ? 1'b0 : wa, "wave a with top");
    end
    wr8(OFS_CTRL_A, {5'h0, TOPSEL_MAX});
    wr16(OFS_COUNT_LO, BOTTOM_VAL);
    settle();
    chk(bottom_flag, 1'b1, "bottom");
    chk(max_flag, 1'b0, "max at zero");
    wr8(OFS_FLAG, 8'h0F);
    wr16(OFS_COUNT_LO, 16'hFFFE);
    wr8(OFS_CTRL_B, {5'h0, CS_DIV1});
    wr8(OFS_CTRL_B, {5'h0, CS_NONE});
    rd8(OFS_FLAG, 8'h01, 8'h01);
    $display("test top and limits done");
    repeat (4) @(posedge clk_sys);
    summarize();
  end
endmodule

// *** hdl/tick_select.sv ***
// Prescaler and clock select that produce the one-cycle timer tick
`timescale 1ns/10ps
module tick_select
  import wide_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic run_en,
  input wire logic [2:0] clock_sel,
  input wire logic ext_pin,
  output logic timer_tick
);
  logic [9:0] presc_ff;
  logic [9:0] nxt_presc;
  logic ext_ff;
  logic nxt_ext;
  logic tick_ff;
  logic nxt_tick;

  // Free prescaler, pin history and tick decode
  always_comb begin
    nxt_presc = run_en ? presc_ff + 10'h001 : 10'h000;
    nxt_ext = ext_pin;
    case (clock_sel)
      CS_NONE: nxt_tick = 1'b0;
      CS_DIV1: nxt_tick = run_en;
      CS_DIV8: nxt_tick = run_en && (presc_ff[2:0] == 3'h7);
      CS_DIV64: nxt_tick = run_en && (presc_ff[5:0] == 6'h3F);
      CS_DIV256: nxt_tick = run_en && (presc_ff[7:0] == 8'hFF);
      CS_DIV1024: nxt_tick = run_en && (presc_ff == 10'h3FF);
      CS_EXT_FALL: nxt_tick = run_en && ext_ff && !ext_pin;
      CS_EXT_RISE: nxt_tick = run_en && !ext_ff && ext_pin;
      default: nxt_tick = 1'b0;
    endcase
  end

  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      presc_ff <= 10'h000;
      ext_ff <= 1'b0;
      tick_ff <= 1'b0;
    end else begin
      presc_ff <= nxt_presc;
      ext_ff <= nxt_ext;
      tick_ff <= nxt_tick;
    end
  end

  assign timer_tick = tick_ff;
endmodule

// *** hdl/wide_timer_core.sv ***
// Byte-accessed 16-bit timer core with AHB-Lite register slave
//
// Local design decisions: the register addresses and register access over AHB-Lite.
`timescale 1ns/10ps
// What this block does
// - Power gate bit set keeps timer disabled
// - Four 16-bit values reached as byte pairs
// - One shared high-byte holding register
// - Low-byte write loads full 16-bit target
// - Count or capture low-byte read copies high byte to holder
// - Compare reads return high byte directly
// - Count advances only on selected tick
// - Buffered compares checked against count on each tick
// - Compare match sets channel flag
// - Capture event copies count to capture
// - Count zero signals BOTTOM
// - All-ones count signals MAX
// - Mode selects TOP: fixed, compare A, capture
// - Compare A as TOP gives no output
// - Capture as TOP frees compare A output
// - Flags visible, individually masked
// - Software count write beats counting
module wide_timer_core
  import wide_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_count_pin,
  input wire logic capture_pin,
  input wire logic comparator_out,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic bottom_flag,
  output logic max_flag,
  output logic top_flag,
  output logic irq_req
);
  bus_state_t state_ff, nxt_state;
  logic [7:0] addr_ff, nxt_addr;
  logic wr_ff, nxt_wr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] hold_ff, nxt_hold;
  logic [15:0] count_ff, nxt_count;
  logic [15:0] cmpa_ff, nxt_cmpa, cmpa_act_ff, nxt_cmpa_act;
  logic [15:0] cmpb_ff, nxt_cmpb, cmpb_act_ff, nxt_cmpb_act;
  logic [15:0] capt_ff, nxt_capt;
  logic [7:0] ctrla_ff, nxt_ctrla, ctrlb_ff, nxt_ctrlb;
  logic [3:0] flag_ff, nxt_flag, mask_ff, nxt_mask;
  logic [7:0] power_ff, nxt_power;
  logic capt_in_ff, nxt_capt_in;
  logic wave_a_ff, nxt_wave_a, wave_b_ff, nxt_wave_b;
  logic bot_ff, max_ff, top_ff, irq_ff;
  logic nxt_bot, nxt_max, nxt_top, nxt_irq;
  logic tick;
  logic tick_raw;
  logic run_en;
  logic [15:0] top_val;
  logic at_top, match_a, match_b, capt_evt;
  logic wr_go, rd_go;
  logic [7:0] wbyte;
  logic [3:0] flag_set, flag_clr;

  // Byte lane of a 16-bit value selected by the high flag
  function automatic logic [7:0] byte_of(input logic [15:0] v,
                                         input logic hi);
    byte_of = hi ? v[15:8] : v[7:0];
  endfunction

  assign run_en = !power_ff[PWR_GATE_BIT];

  tick_select u_tick (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .run_en(run_en),
    .clock_sel(ctrlb_ff[CS_LSB +: 3]),
    .ext_pin(external_count_pin),
    .timer_tick(tick_raw)
  );

  // Raw tick lags gate and select by a cycle, so mask it here as well
  assign tick = tick_raw && run_en
    && (ctrlb_ff[CS_LSB +: 3] != CS_NONE);

  // TOP selection by mode
  always_comb begin
    case (ctrla_ff[TOPSEL_LSB +: 3])
      TOPSEL_8: top_val = TOP_8BIT;
      TOPSEL_9: top_val = TOP_9BIT;
      TOPSEL_10: top_val = TOP_10BIT;
      TOPSEL_CMPA: top_val = cmpa_act_ff;
      TOPSEL_CAPT: top_val = capt_ff;
      default: top_val = MAX_VAL;
    endcase
  end

  // Match, limit and capture event detection
  assign at_top = (count_ff == top_val);
  assign match_a = run_en && tick && (count_ff == cmpa_act_ff);
  assign match_b = run_en && tick && (count_ff == cmpb_act_ff);
  assign capt_evt = run_en && (ctrlb_ff[CAPT_SRC_BIT] ? comparator_out
    : capture_pin) != capt_in_ff && ((ctrlb_ff[CAPT_SRC_BIT] ?
    comparator_out : capture_pin) == ctrlb_ff[EDGE_SEL_BIT]);

  // Bus decode: writes in the data phase, reads in the address phase
  assign wr_go = (state_ff == BUS_DATA) && wr_ff;
  assign rd_go = (state_ff == BUS_IDLE) && hsel && hready && htrans[1]
    && !hwrite;
  assign wbyte = hwdata[7:0];

  // Bus slave, holding register and all timer state next values
  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_wr = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_hold = hold_ff;
    nxt_count = count_ff;
    nxt_cmpa = cmpa_ff;
    nxt_cmpb = cmpb_ff;
    nxt_cmpa_act = cmpa_act_ff;
    nxt_cmpb_act = cmpb_act_ff;
    nxt_capt = capt_ff;
    nxt_ctrla = ctrla_ff;
    nxt_ctrlb = ctrlb_ff;
    nxt_mask = mask_ff;
    nxt_power = power_ff;
    flag_set = 4'h0;
    flag_clr = 4'h0;
    // Address phase capture; every access takes one data cycle
    if (hsel && hready && htrans[1]) begin
      nxt_state = BUS_DATA;
      nxt_addr = haddr[7:0];
      nxt_wr = hwrite;
    end else begin
      nxt_state = BUS_IDLE;
    end
    // Counting on the tick, wrapping at TOP
    if (tick) begin
      nxt_count = at_top ? BOTTOM_VAL : count_ff + 16'h0001;
      if (at_top) begin
        nxt_cmpa_act = cmpa_ff;
        nxt_cmpb_act = cmpb_ff;
      end
    end
    if (capt_evt) begin
      nxt_capt = count_ff;
    end
    // Reads: count or capture low byte copies high into holder
    if (rd_go) begin
      case (haddr[7:0])
        OFS_COUNT_LO: begin
          nxt_rdata = {24'h0, byte_of(count_ff, 1'b0)};
          nxt_hold = byte_of(count_ff, 1'b1);
        end
        OFS_CAPT_LO: begin
          nxt_rdata = {24'h0, byte_of(capt_ff, 1'b0)};
          nxt_hold = byte_of(capt_ff, 1'b1);
        end
        OFS_COUNT_HI, OFS_CAPT_HI: nxt_rdata = {24'h0, hold_ff};
        OFS_CMPA_LO: nxt_rdata = {24'h0, byte_of(cmpa_ff, 1'b0)};
        OFS_CMPA_HI: nxt_rdata = {24'h0, byte_of(cmpa_ff, 1'b1)};
        OFS_CMPB_LO: nxt_rdata = {24'h0, byte_of(cmpb_ff, 1'b0)};
        OFS_CMPB_HI: nxt_rdata = {24'h0, byte_of(cmpb_ff, 1'b1)};
        OFS_CTRL_A: nxt_rdata = {24'h0, ctrla_ff};
        OFS_CTRL_B: nxt_rdata = {24'h0, ctrlb_ff};
        OFS_FLAG: nxt_rdata = {28'h0, flag_ff};
        OFS_MASK: nxt_rdata = {28'h0, mask_ff};
        OFS_POWER: nxt_rdata = {24'h0, power_ff};
        default: nxt_rdata = 32'h0000_0000;
      endcase
    end
    // Writes in the data phase
    if (wr_go) begin
      case (addr_ff)
        OFS_COUNT_HI, OFS_CMPA_HI, OFS_CMPB_HI, OFS_CAPT_HI:
          nxt_hold = wbyte;
        OFS_COUNT_LO: nxt_count = {hold_ff, wbyte};
        OFS_CMPA_LO: nxt_cmpa = {hold_ff, wbyte};
        OFS_CMPB_LO: nxt_cmpb = {hold_ff, wbyte};
        OFS_CAPT_LO: nxt_capt = {hold_ff, wbyte};
        OFS_CTRL_A: nxt_ctrla = wbyte;
        OFS_CTRL_B: nxt_ctrlb = wbyte;
        OFS_FLAG: flag_clr = wbyte[3:0];
        OFS_MASK: nxt_mask = wbyte[3:0];
        OFS_POWER: nxt_power = wbyte;
        default: nxt_power = power_ff;
      endcase
    end
    // Compare values load straight through while stopped
    if (!run_en || ctrlb_ff[CS_LSB +: 3] == CS_NONE) begin
      nxt_cmpa_act = nxt_cmpa;
      nxt_cmpb_act = nxt_cmpb;
    end
    // Flags: set wins over clear
    flag_set[FLG_OVF] = tick && (count_ff == MAX_VAL || at_top);
    flag_set[FLG_CMPA] = match_a;
    flag_set[FLG_CMPB] = match_b;
    flag_set[FLG_CAPT] = capt_evt;
    nxt_flag = (flag_ff & ~flag_clr) | flag_set;
    nxt_irq = |(nxt_flag & nxt_mask);
    nxt_capt_in = ctrlb_ff[CAPT_SRC_BIT] ? comparator_out : capture_pin;
    // Waveforms: toggle on match, compare A silent when it is TOP
    nxt_wave_a = wave_a_ff;
    if (ctrla_ff[TOPSEL_LSB +: 3] == TOPSEL_CMPA) begin
      nxt_wave_a = 1'b0;
    end else if (match_a) begin
      nxt_wave_a = !wave_a_ff;
    end
    nxt_wave_b = match_b ? !wave_b_ff : wave_b_ff;
    nxt_bot = (nxt_count == BOTTOM_VAL);
    nxt_max = (nxt_count == MAX_VAL);
    nxt_top = (nxt_count == top_val);
  end

  // State registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= BUS_IDLE;
      addr_ff <= 8'h00;
      wr_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      hold_ff <= 8'h00;
      count_ff <= 16'h0000;
      cmpa_ff <= 16'h0000;
      cmpb_ff <= 16'h0000;
      cmpa_act_ff <= 16'h0000;
      cmpb_act_ff <= 16'h0000;
      capt_ff <= 16'h0000;
      ctrla_ff <= 8'h00;
      ctrlb_ff <= 8'h00;
      flag_ff <= 4'h0;
      mask_ff <= 4'h0;
      power_ff <= POWER_RST;
      capt_in_ff <= 1'b0;
      wave_a_ff <= 1'b0;
      wave_b_ff <= 1'b0;
      bot_ff <= 1'b1;
      max_ff <= 1'b0;
      top_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      rdata_ff <= nxt_rdata;
      hold_ff <= nxt_hold;
      count_ff <= nxt_count;
      cmpa_ff <= nxt_cmpa;
      cmpb_ff <= nxt_cmpb;
      cmpa_act_ff <= nxt_cmpa_act;
      cmpb_act_ff <= nxt_cmpb_act;
      capt_ff <= nxt_capt;
      ctrla_ff <= nxt_ctrla;
      ctrlb_ff <= nxt_ctrlb;
      flag_ff <= nxt_flag;
      mask_ff <= nxt_mask;
      power_ff <= nxt_power;
      capt_in_ff <= nxt_capt_in;
      wave_a_ff <= nxt_wave_a;
      wave_b_ff <= nxt_wave_b;
      bot_ff <= nxt_bot;
      max_ff <= nxt_max;
      top_ff <= nxt_top;
      irq_ff <= nxt_irq;
    end
  end

  // Outputs straight from flops; slave is always ready and OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_ff;
  assign wave_out_a = wave_a_ff;
  assign wave_out_b = wave_b_ff;
  assign bottom_flag = bot_ff;
  assign max_flag = max_ff;
  assign top_flag = top_ff;
  assign irq_req = irq_ff;

  // Checks, all on the system clock and quiet during reset
  default clocking cb_sys @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // Read address phases that the byte-pair checks start from
  sequence seq_count_lo_read;
    rd_go && haddr[7:0] == OFS_COUNT_LO;
  endsequence
  sequence seq_hold_hi_read;
    rd_go && (haddr[7:0] == OFS_COUNT_HI || haddr[7:0] == OFS_CAPT_HI);
  endsequence
  sequence seq_cmpa_hi_read;
    rd_go && haddr[7:0] == OFS_CMPA_HI;
  endsequence
  sequence seq_cmpb_hi_read;
    rd_go && haddr[7:0] == OFS_CMPB_HI;
  endsequence

  chk_gate_holds: assert property (!run_en |-> !tick)
    else $error("tick while gated");
  chk_low_write: assert property (wr_go && addr_ff == OFS_COUNT_LO
    |=> count_ff == $past({hold_ff, hwdata[7:0]}))
    else $error("count low write lost");
  chk_high_write: assert property (wr_go && addr_ff == OFS_CMPA_HI
    |=> cmpa_ff == $past(cmpa_ff)) else $error("high write changed target");
  chk_hold_copy: assert property (seq_count_lo_read
    |=> hold_ff == $past(count_ff[15:8])) else $error("hold not loaded");
  chk_cmp_direct: assert property (seq_cmpb_hi_read
    |=> hrdata[7:0] == $past(cmpb_ff[15:8])) else $error("cmp hi read");
  chk_idle_count: assert property (!tick && !wr_go
    |=> count_ff == $past(count_ff)) else $error("count moved without tick");
  chk_match_flag: assert property (match_a |=> flag_ff[FLG_CMPA])
    else $error("flag A missed");
  chk_capture: assert property (capt_evt && !wr_go
    |=> capt_ff == $past(count_ff)) else $error("capture lost");
  chk_bottom: assert property (bottom_flag == (count_ff == BOTTOM_VAL))
    else $error("bottom");
  chk_max_flag: assert property (max_flag == (count_ff == MAX_VAL))
    else $error("max");
  chk_irq_mask: assert property (irq_req == |(flag_ff & mask_ff))
    else $error("irq mask");
  chk_write_wins: assert property (wr_go && addr_ff == OFS_COUNT_LO
    && tick |=> count_ff == $past({hold_ff, hwdata[7:0]}))
    else $error("count write lost to tick");
  chk_a_silent: assert property (
    ctrla_ff[TOPSEL_LSB +: 3] == TOPSEL_CMPA |=> !wave_out_a)
    else $error("wave A active as TOP");
  chk_gate_count: assert property (!run_en && !wr_go
    |=> count_ff == $past(count_ff)) else $error("count moved while gated");
  chk_stop_count: assert property (!wr_go
    && ctrlb_ff[CS_LSB +: 3] == CS_NONE |=> count_ff == $past(count_ff))
    else $error("count moved with no source");
  chk_hold_return: assert property (seq_hold_hi_read
    |=> hrdata[7:0] == $past(hold_ff)) else $error("hold not returned");
  chk_cmpa_direct: assert property (seq_cmpa_hi_read
    |=> hrdata[7:0] == $past(cmpa_ff[15:8])) else $error("cmp A hi read");
  chk_match_b: assert property (match_b |=> flag_ff[FLG_CMPB])
    else $error("flag B missed");
  chk_hold_write: assert property (wr_go && addr_ff == OFS_CMPB_HI
    |=> hold_ff == $past(hwdata[7:0])) else $error("holder not written");
endmodule

// *** hdl/wide_timer_pkg.sv ***
// Shared constants for the byte-accessed 16-bit timer core
package wide_timer_pkg;
  // Register word offsets (byte addresses on the AHB-Lite bus)
  localparam logic [7:0] OFS_COUNT_LO = 8'h00;
  localparam logic [7:0] OFS_COUNT_HI = 8'h04;
  localparam logic [7:0] OFS_CMPA_LO = 8'h08;
  localparam logic [7:0] OFS_CMPA_HI = 8'h0C;
  localparam logic [7:0] OFS_CMPB_LO = 8'h10;
  localparam logic [7:0] OFS_CMPB_HI = 8'h14;
  localparam logic [7:0] OFS_CAPT_LO = 8'h18;
  localparam logic [7:0] OFS_CAPT_HI = 8'h1C;
  localparam logic [7:0] OFS_CTRL_A = 8'h20;
  localparam logic [7:0] OFS_CTRL_B = 8'h24;
  localparam logic [7:0] OFS_FLAG = 8'h28;
  localparam logic [7:0] OFS_MASK = 8'h2C;
  localparam logic [7:0] OFS_POWER = 8'h30;
  // Timer control B fields
  localparam int CS_LSB = 0;
  localparam int EDGE_SEL_BIT = 6;
  localparam int CAPT_SRC_BIT = 5;
  // Timer control A field: top select
  localparam int TOPSEL_LSB = 0;
  // Flag and mask bit positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CMPA = 1;
  localparam int FLG_CMPB = 2;
  localparam int FLG_CAPT = 3;
  // Power register bit
  localparam int PWR_GATE_BIT = 0;
  localparam logic [7:0] POWER_RST = 8'h01;
  // Count limits
  localparam logic [15:0] BOTTOM_VAL = 16'h0000;
  localparam logic [15:0] MAX_VAL = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;
  // Top select encodings
  localparam logic [2:0] TOPSEL_MAX = 3'h0;
  localparam logic [2:0] TOPSEL_8 = 3'h1;
  localparam logic [2:0] TOPSEL_9 = 3'h2;
  localparam logic [2:0] TOPSEL_10 = 3'h3;
  localparam logic [2:0] TOPSEL_CMPA = 3'h4;
  localparam logic [2:0] TOPSEL_CAPT = 3'h5;
  // Clock select encodings
  localparam logic [2:0] CS_NONE = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  // Bus phase states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_DATA = 2'b01
  } bus_state_t;
endpackage
